// File: include/ts_event_regs.svh
/*
  register offsets, field positions, reset values and timing counts
  of the timestamp event timer. assumes a 100 mhz system clock.
*/
`ifndef TS_EVENT_REGS_SVH
`define TS_EVENT_REGS_SVH
// ---------------------------------------------------------------
// word offsets (byte address = 4 * index)
// ---------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_BEGIN_LO 4'h1
`define REG_BEGIN_HI 4'h2
`define REG_IVAL_LO 4'h3
`define REG_IVAL_HI 4'h4
`define REG_FIRST_LO 4'h5
`define REG_FIRST_HI 4'h6
`define REG_TIME_LO 4'h7
`define REG_TIME_HI 4'h8
`define REG_STATUS 4'h9
`define REG_MAC_LO 4'ha
`define REG_MAC_HI 4'hb
`define REG_ID_LO 4'hc
`define REG_ID_HI 4'hd
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define CTRL_ENABLE 0
`define CTRL_SYNC 1
`define CTRL_CLEAR 2
`define CTRL_RESET 32'h0000_0000
// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define STAT_RUN 0
`define STAT_ARMED 1
`define STAT_MASTER 2
`define STAT_SETTLED 3
// ---------------------------------------------------------------
// identity insert and timing
// ---------------------------------------------------------------
`define ID_INSERT 16'hfffe
`define CLK_NS 10
`define LOCAL_TICK_NS 1000
`define LOCAL_TICK_CYC (`LOCAL_TICK_NS / `CLK_NS)
`define SYNC_TICK_NS 8
`define SETTLE_MS 2000
`define SETTLE_CYC (`SETTLE_MS * 1000000 / `CLK_NS)
`endif

// File: include/ts_event_pkg.sv
/*
  types shared by the timestamp event timer files.
  assumes nothing of its surroundings.
*/
package ts_event_pkg;
  // avalon-mm request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } avm_req_t;
  // avalon-mm answer to the master
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } avm_rsp_t;
  // scheduler states
  typedef enum logic [2:0] {
    SCH_IDLE = 3'b001,
    SCH_ARMED = 3'b010,
    SCH_RUN = 3'b100
  } sched_state_t;
endpackage : ts_event_pkg

// File: rtl/tick_divider.sv
/*
  divider that gives a one-cycle enable every DIV clock cycles.
  assumes one synchronous clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 100
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  initial begin
    if (DIV < 1) $error("divide ratio must be at least one");
  end
  logic [31:0] cnt; // cycles since last tick
  logic [31:0] next_cnt;
  // wrap at DIV-1 and pulse
  always_comb begin
    next_cnt = (cnt == 32'(DIV - 1)) ? 32'h0000_0000 : cnt + 32'h0000_0001;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 32'h0000_0000;
    end else begin
      cnt <= next_cnt;
    end
  end
  assign tick = (cnt == 32'(DIV - 1));
endmodule : tick_divider
`default_nettype wire

// File: rtl/master_elect.sv
/*
  master election among equal peers and clock identity derivation.
  assumes peer mac address arrives with a one-cycle valid strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ts_event_regs.svh"
module master_elect #(
  parameter int SETTLE_CYC = `SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic syncOn,
  input wire logic [47:0] macAddr,
  input wire logic peerValid,
  input wire logic [47:0] peerMac,
  output logic [63:0] clockId,
  output logic isMaster,
  output logic settled
);
  initial begin
    if (SETTLE_CYC < 1) $error("settle count must be at least one");
  end
  // ---------------------------------------------------------------
  // election state
  // ---------------------------------------------------------------
  logic [47:0] bestMac; // lowest mac seen so far
  logic [47:0] next_bestMac;
  logic [31:0] settleCnt; // cycles since sync mode went on
  logic [31:0] next_settleCnt;
  logic done; // settle window over
  logic next_done;
  // lowest mac wins; window restarts when sync goes on
  always_comb begin
    next_bestMac = bestMac;
    next_settleCnt = settleCnt;
    next_done = done;
    if (!syncOn) begin
      next_bestMac = macAddr;
      next_settleCnt = 32'h0000_0000;
      next_done = 1'b0;
    end else begin
      if (peerValid && peerMac < bestMac) begin
        next_bestMac = peerMac; // [R14]
      end
      if (!done) begin
        next_settleCnt = settleCnt + 32'h0000_0001;
        next_done = (settleCnt == 32'(SETTLE_CYC - 1)); // [R15]
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bestMac <= 48'hffff_ffff_ffff;
      settleCnt <= 32'h0000_0000;
      done <= 1'b0;
    end else begin
      bestMac <= next_bestMac;
      settleCnt <= next_settleCnt;
      done <= next_done;
    end
  end
  // identity: upper three octets, insert, lower three octets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clockId <= 64'h0000_0000_0000_0000;
    end else begin
      clockId <= {macAddr[47:24], `ID_INSERT, macAddr[23:0]}; // [R13]
    end
  end
  assign isMaster = syncOn && (bestMac == macAddr); // [R14]
  assign settled = done;
  a_settle_time: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
    $rose(done) |-> syncOn && settleCnt == 32'(SETTLE_CYC))
    else $error("role settled at wrong time");
  // identity follows the address one cycle later; skipped on the release edge
  a_id_insert: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    $past(rst_n) |-> clockId == {$past(macAddr[47:24]), `ID_INSERT, $past(macAddr[23:0])})
    else $error("clock identity insert wrong");
endmodule : master_elect
`default_nettype wire

// File: rtl/ts_event_timer.sv
/*
  timestamp timebase with periodic event generator and avalon-mm slave.
  assumes a 100 mhz clock, synchronous inputs, and a sync tick input
  whose every pulse adds syncStep counts of 8 ns of network time (several counts per pulse
  are carried by syncStep).
*/
// Overview of operation
// [R01] local counter advances once per microsecond
// [R02] synced counter advances 8 ns per tick; code adds syncStep counts of 8 ns per tick
// [R03] both counters run freely, no enable
// [R04] clear zeroes timestamp only with sync off
// [R05] sync mode selects synced base, clear-immune
// [R06] first event at boundary after begin time
// [R07] further event every interval until stopped
// [R08] first event time stored, readable
// [R09] near-boundary begin may slip one interval
// [R10] clear before first event keeps stored time
// [R11] clear while running restarts at next boundary
// [R12] new interval counts from previous event
// [R13] identity is mac with fffe inserted
// [R14] lowest mac becomes master among equals
// [R15] role settles about two seconds after enable
// [R16] each event is a one-cycle trigger pulse
// [R17] software sets begin, nonzero interval first
`timescale 1ns/1ps
`default_nettype none
`include "ts_event_regs.svh"
module ts_event_timer
  import ts_event_pkg::*;
#(
  parameter int SETTLE_CYC = `SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ts_event_pkg::avm_req_t avmReq,
  output ts_event_pkg::avm_rsp_t avmRsp,
  input wire logic syncTick,
  input wire logic [7:0] syncStep,
  input wire logic [47:0] macAddr,
  input wire logic peerValid,
  input wire logic [47:0] peerMac,
  output logic first_frame_event,
  output logic [63:0] timestamp,
  output logic clockMaster
);
  import ts_event_pkg::*;
  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // replace one 32-bit half of a 64-bit value
  function automatic logic [63:0] setHalf(input logic [63:0] v, input logic hi,
                                          input logic [31:0] d);
    setHalf = hi ? {d, v[31:0]} : {v[63:32], d};
  endfunction : setHalf
  // first multiple of ival strictly above t
  function automatic logic [63:0] nextBoundary(input logic [63:0] t,
                                               input logic [63:0] ival);
    logic [63:0] iv;
    iv = (ival == 64'h0) ? 64'h1 : ival;
    nextBoundary = t - (t % iv) + iv;
  endfunction : nextBoundary
  // ---------------------------------------------------------------
  // local tick enable and sub-blocks
  // ---------------------------------------------------------------
  logic localTick; // one pulse per microsecond
  tick_divider #(.DIV(`LOCAL_TICK_CYC)) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .tick(localTick)
  );
  logic [31:0] ctrl; // enable, sync mode
  logic [63:0] clockId;
  logic isMaster;
  logic settled;
  master_elect #(.SETTLE_CYC(SETTLE_CYC)) u_elect (
    .clk(clk),
    .rst_n(rst_n),
    .syncOn(ctrl[`CTRL_SYNC]),
    .macAddr(macAddr),
    .peerValid(peerValid),
    .peerMac(peerMac),
    .clockId(clockId),
    .isMaster(isMaster),
    .settled(settled)
  );
  assign clockMaster = isMaster;
  // ---------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------
  logic [63:0] beginTime; // periodic_event_begin_time
  logic [63:0] ivalTime; // periodic_event_interval
  logic [63:0] next_beginTime;
  logic [63:0] next_ivalTime;
  logic [31:0] next_ctrl;
  logic clearCmd; // timebase_clear_cmd pulse
  logic wrAcc; // write accepted this cycle
  logic rdPend; // read answer pending
  logic next_rdPend;
  logic [31:0] rdData;
  logic [31:0] next_rdData;
  logic [63:0] firstTime; // periodic_event_first_time
  sched_state_t state;
  assign wrAcc = avmReq.write;
  assign clearCmd = wrAcc && avmReq.address == `REG_CTRL
                    && avmReq.writedata[`CTRL_CLEAR];
  // write decode, clear bit self-clearing
  always_comb begin
    next_ctrl = ctrl;
    next_beginTime = beginTime;
    next_ivalTime = ivalTime;
    if (wrAcc) begin
      case (avmReq.address)
        `REG_CTRL: next_ctrl = {30'h0, avmReq.writedata[`CTRL_SYNC],
                                avmReq.writedata[`CTRL_ENABLE]};
        `REG_BEGIN_LO: next_beginTime = setHalf(beginTime, 1'b0, avmReq.writedata);
        `REG_BEGIN_HI: next_beginTime = setHalf(beginTime, 1'b1, avmReq.writedata);
        `REG_IVAL_LO: next_ivalTime = setHalf(ivalTime, 1'b0, avmReq.writedata);
        `REG_IVAL_HI: next_ivalTime = setHalf(ivalTime, 1'b1, avmReq.writedata);
        default: ;
      endcase
    end
  end
  // read mux: one wait cycle, then data
  always_comb begin
    next_rdPend = avmReq.read && !rdPend;
    next_rdData = rdData;
    if (avmReq.read && !rdPend) begin
      case (avmReq.address)
        `REG_CTRL: next_rdData = ctrl;
        `REG_BEGIN_LO: next_rdData = beginTime[31:0];
        `REG_BEGIN_HI: next_rdData = beginTime[63:32];
        `REG_IVAL_LO: next_rdData = ivalTime[31:0];
        `REG_IVAL_HI: next_rdData = ivalTime[63:32];
        `REG_FIRST_LO: next_rdData = firstTime[31:0]; // [R08]
        `REG_FIRST_HI: next_rdData = firstTime[63:32]; // [R08]
        `REG_TIME_LO: next_rdData = timestamp[31:0];
        `REG_TIME_HI: next_rdData = timestamp[63:32];
        `REG_STATUS: next_rdData = {28'h0, settled, isMaster,
                                    state == SCH_ARMED, state == SCH_RUN};
        `REG_MAC_LO: next_rdData = macAddr[31:0];
        `REG_MAC_HI: next_rdData = {16'h0, macAddr[47:32]};
        `REG_ID_LO: next_rdData = clockId[31:0];
        `REG_ID_HI: next_rdData = clockId[63:32];
        default: next_rdData = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CTRL_RESET;
      beginTime <= 64'h0;
      ivalTime <= 64'h0;
      rdPend <= 1'b0;
      rdData <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      beginTime <= next_beginTime;
      ivalTime <= next_ivalTime;
      rdPend <= next_rdPend;
      rdData <= next_rdData;
    end
  end
  // one driver for the whole answer: waitrequest only for a read not yet latched
  assign avmRsp = {avmReq.read && !rdPend, rdData};
  // ---------------------------------------------------------------
  // timebase counters
  // ---------------------------------------------------------------
  logic [63:0] localCnt; // microsecond count
  logic [63:0] syncCnt; // network 8 ns count
  logic [63:0] next_localCnt;
  logic [63:0] next_syncCnt;
  logic syncOn;
  assign syncOn = ctrl[`CTRL_SYNC];
  // free running, local cleared always, synced never
  always_comb begin
    next_localCnt = localCnt + {63'h0, localTick}; // [R01] [R03]
    next_syncCnt = syncCnt + (syncTick ? {56'h0, syncStep} : 64'h0); // [R02] [R03]
    if (clearCmd) begin
      next_localCnt = 64'h0; // [R04]
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      localCnt <= 64'h0;
      syncCnt <= 64'h0;
    end else begin
      localCnt <= next_localCnt;
      syncCnt <= next_syncCnt;
    end
  end
  // selector follows sync mode automatically
  always_comb begin
    timestamp = syncOn ? syncCnt : localCnt; // [R05]
  end
  // ---------------------------------------------------------------
  // event scheduler
  // ---------------------------------------------------------------
  logic [63:0] nextEvt; // time of next event
  logic [63:0] lastEvt; // time of previous event
  logic [63:0] next_nextEvt;
  logic [63:0] next_lastEvt;
  logic [63:0] next_firstTime;
  sched_state_t next_state;
  logic next_fire;
  logic hit; // timestamp reached target
  logic tsClr; // selected timebase cleared
  assign hit = (timestamp >= nextEvt);
  assign tsClr = clearCmd && !syncOn; // [R04] [R05]
  always_comb begin
    next_state = state;
    next_nextEvt = nextEvt;
    next_lastEvt = lastEvt;
    next_firstTime = firstTime;
    next_fire = 1'b0;
    case (state)
      SCH_IDLE: begin
        // begin time latched; boundary past it, begin on a boundary slips [R09]
        if (ctrl[`CTRL_ENABLE] && ivalTime != 64'h0) begin // [R17]
          next_nextEvt = nextBoundary(beginTime, ivalTime); // [R06]
          next_firstTime = nextBoundary(beginTime, ivalTime); // [R08]
          next_state = SCH_ARMED;
        end
      end
      SCH_ARMED: begin
        // a clear keeps the stored target; fires when count returns [R10]
        if (!ctrl[`CTRL_ENABLE]) begin
          next_state = SCH_IDLE;
        end else if (hit && !tsClr) begin
          next_fire = 1'b1;
          next_lastEvt = nextEvt;
          next_nextEvt = nextEvt + ivalTime; // [R07]
          next_state = SCH_RUN;
        end
      end
      SCH_RUN: begin
        if (!ctrl[`CTRL_ENABLE]) begin
          next_state = SCH_IDLE; // [R07]
        end else if (tsClr) begin
          next_lastEvt = 64'h0;
          next_nextEvt = ivalTime; // [R11]
        end else if (wrAcc && (avmReq.address == `REG_IVAL_LO
                               || avmReq.address == `REG_IVAL_HI)) begin
          next_nextEvt = lastEvt + next_ivalTime; // [R12]
        end else if (hit) begin
          next_fire = 1'b1;
          next_lastEvt = nextEvt;
          next_nextEvt = nextEvt + ivalTime; // [R07]
        end
      end
      default: next_state = SCH_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SCH_IDLE;
      nextEvt <= 64'h0;
      lastEvt <= 64'h0;
      firstTime <= 64'h0;
      first_frame_event <= 1'b0;
    end else begin
      state <= next_state;
      nextEvt <= next_nextEvt;
      lastEvt <= next_lastEvt;
      firstTime <= next_firstTime;
      first_frame_event <= next_fire; // [R16]
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_fire_hit;
    state != SCH_IDLE && ctrl[`CTRL_ENABLE] && hit && !tsClr;
  endsequence
  a_event_pulse: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
    first_frame_event |=> !first_frame_event)
    else $error("event pulse longer than one cycle");
  a_local_clear: assert property (@(posedge clk) disable iff (!rst_n) // [R04]
    clearCmd |=> localCnt == 64'h0)
    else $error("local counter not cleared");
  // the synced count keeps its normal step across a clear, tick or no tick
  a_sync_immune: assert property (@(posedge clk) disable iff (!rst_n) // [R05]
    clearCmd |=> syncCnt == $past(syncCnt) + {56'h0, ($past(syncTick) ? $past(syncStep) : 8'h00)})
    else $error("synced counter disturbed by clear");
  a_local_rate: assert property (@(posedge clk) disable iff (!rst_n) // [R01]
    !clearCmd && !localTick |=> localCnt == $past(localCnt))
    else $error("local counter moved without tick");
  a_first_store: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    state == SCH_ARMED && tsClr |=> firstTime == $past(firstTime))
    else $error("first event time changed by clear");
  a_event_fires: assert property (@(posedge clk) disable iff (!rst_n) // [R06] [R07]
    s_fire_hit |=> first_frame_event)
    else $error("event missed at boundary");
  a_first_after: assert property (@(posedge clk) disable iff (!rst_n) // [R06]
    state == SCH_ARMED |-> firstTime > beginTime)
    else $error("first event not after begin time");
  a_clear_restart: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    state == SCH_RUN && ctrl[`CTRL_ENABLE] && tsClr |=> nextEvt == ivalTime)
    else $error("restart boundary wrong after clear");
  a_sync_select: assert property (@(posedge clk) disable iff (!rst_n) // [R05]
    syncOn |-> timestamp == syncCnt)
    else $error("sync mode did not select synced base");
endmodule : ts_event_timer
`default_nettype wire

// File: test/trigger_partner.sv
/*
  model of the far side: network time source and frame trigger logic.
  assumes the 100 mhz bench clock and the timer's active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module trigger_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frameEvent,
  output logic syncTick,
  output logic [7:0] syncStep,
  output logic [15:0] eventCount
);
  // ------------------------------------------------------------
  // network time and trigger count
  // ------------------------------------------------------------
  logic [1:0] phase; // position in the 1,1,1,2 step pattern
  // 10 ns of network time per cycle is 1.25 counts of 8 ns
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
      syncTick <= 1'b0;
      syncStep <= 8'h00;
      eventCount <= 16'h0;
    end else begin
      phase <= phase + 2'h1;
      syncTick <= 1'b1;
      syncStep <= (phase == 2'h3) ? 8'h02 : 8'h01;
      // each trigger pulse starts one acquisition
      if (frameEvent) begin
        eventCount <= eventCount + 16'h1;
      end
    end
  end
endmodule : trigger_partner
`default_nettype wire

// File: test/timestamp_modulo_event_timer_test.sv
/*
  self-checking bench for the timestamp event timer.
  assumes the design package, register header and partner model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ts_event_regs.svh"
module timestamp_modulo_event_timer_test;
  import ts_event_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [47:0] OWN_MAC = 48'h0a1b2c3d4e5f; // own address, arbitrary
  logic clk = 1'b0; // system clock
  logic rst_n = 1'b0; // reset, active low
  avm_req_t avmReq = '0; // bus request
  avm_rsp_t avmRsp; // bus answer
  logic syncTick; // network tick from partner
  logic [7:0] syncStep; // counts per network tick
  logic peerValid = 1'b0; // peer announcement strobe
  logic [47:0] peerMac = 48'h0; // announced peer address
  logic first_frame_event; // periodic trigger pulse
  logic [63:0] timestamp; // selected timebase
  logic clockMaster; // master role
  logic [15:0] eventCount; // pulses seen by partner
  logic [31:0] rdData; // last read word
  logic [63:0] ts0; // saved timestamp
  int badCount = 0; // mismatches
  int numChecks = 0; // comparisons
  int cycleCount = 0; // timeout counter
  always #5 clk = ~clk;
  ts_event_timer #(.SETTLE_CYC(50)) DUT (.clk(clk), .rst_n(rst_n), .avmReq(avmReq),
    .avmRsp(avmRsp), .syncTick(syncTick), .syncStep(syncStep), .macAddr(OWN_MAC),
    .peerValid(peerValid), .peerMac(peerMac), .first_frame_event(first_frame_event),
    .timestamp(timestamp), .clockMaster(clockMaster));
  trigger_partner partner (.clk(clk), .rst_n(rst_n), .frameEvent(first_frame_event),
    .syncTick(syncTick), .syncStep(syncStep), .eventCount(eventCount));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // request held until waitrequest is seen low at a rising edge, released there
  task automatic bus_write(input logic [3:0] addr, input logic [31:0] data);
    @(posedge clk);
    avmReq.write <= 1'b1;
    avmReq.address <= addr;
    avmReq.writedata <= data;
    do begin
      @(posedge clk);
    end while (avmRsp.waitrequest !== 1'b0);
    avmReq.write <= 1'b0;
  endtask : bus_write
  // read data taken at the same edge that shows waitrequest low
  task automatic bus_read(input logic [3:0] addr);
    @(posedge clk);
    avmReq.read <= 1'b1;
    avmReq.address <= addr;
    do begin
      @(posedge clk);
    end while (avmRsp.waitrequest !== 1'b0);
    rdData = avmRsp.readdata;
    avmReq.read <= 1'b0;
  endtask : bus_read
  // a value never reached shows up as a mismatch
  task automatic wait_ts(input logic [63:0] value);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (timestamp !== value && n < 6000);
    check(timestamp, value);
  endtask : wait_ts
  // waits for a pulse, checks its time and its one-cycle width
  task automatic wait_event(input logic [63:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (first_frame_event !== 1'b1 && n < 6000);
    check(timestamp, exp);
    @(negedge clk);
    check({63'h0, first_frame_event}, 64'h0);
  endtask : wait_event
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset_values();
    logic [63:0] id;
    id = {OWN_MAC[47:24], 16'hfffe, OWN_MAC[23:0]};
    bus_read(`REG_CTRL);
    check({32'h0, rdData}, 64'h0);
    bus_read(4'he);
    check({32'h0, rdData}, 64'h0);
    bus_read(`REG_ID_LO);
    check({32'h0, rdData}, {32'h0, id[31:0]});
    bus_read(`REG_ID_HI);
    check({32'h0, rdData}, {32'h0, id[63:32]});
  endtask : test_reset_values
  task automatic test_local_tick();
    int n;
    n = 0;
    bus_write(`REG_CTRL, 32'h4);
    @(negedge clk);
    ts0 = timestamp;
    wait_ts(ts0 + 64'h1);
    do begin
      @(negedge clk);
      n++;
    end while (timestamp === ts0 + 64'h1 && n < 300);
    check(64'(n), 64'd100);
    check(timestamp, ts0 + 64'h2);
  endtask : test_local_tick
  task automatic test_schedule();
    bus_write(`REG_BEGIN_LO, 32'd20);
    bus_write(`REG_BEGIN_HI, 32'h0);
    bus_write(`REG_IVAL_LO, 32'd10);
    bus_write(`REG_IVAL_HI, 32'h0);
    bus_write(`REG_CTRL, 32'h4);
    bus_write(`REG_CTRL, 32'h1);
    wait_ts(64'd25);
    bus_write(`REG_CTRL, 32'h5);
    wait_event(64'd30);
    bus_read(`REG_FIRST_LO);
    check({32'h0, rdData}, 64'd30);
    wait_event(64'd40);
    wait_ts(64'd45);
    bus_write(`REG_CTRL, 32'h5);
    wait_event(64'd10);
    bus_write(`REG_IVAL_LO, 32'd20);
    wait_event(64'd30);
    bus_write(`REG_CTRL, 32'h0);
    repeat (2500) @(negedge clk);
    check({48'h0, eventCount}, 64'd4);
  endtask : test_schedule
  // begin time exactly on a boundary waits for the following one
  task automatic test_boundary();
    bus_write(`REG_BEGIN_LO, 32'd10);
    bus_write(`REG_IVAL_LO, 32'd10);
    bus_write(`REG_CTRL, 32'h4);
    bus_write(`REG_CTRL, 32'h1);
    wait_event(64'd20);
    bus_read(`REG_FIRST_LO);
    check({32'h0, rdData}, 64'd20);
    bus_write(`REG_CTRL, 32'h0);
  endtask : test_boundary
  task automatic test_sync();
    bus_write(`REG_CTRL, 32'h2);
    bus_read(`REG_STATUS);
    check({63'h0, rdData[`STAT_SETTLED]}, 64'h0);
    @(negedge clk);
    ts0 = timestamp;
    repeat (40) @(negedge clk);
    check(timestamp - ts0, 64'd50);
    ts0 = timestamp;
    bus_write(`REG_CTRL, 32'h6);
    @(negedge clk);
    check({63'h0, timestamp >= ts0}, 64'h1);
    @(posedge clk);
    peerValid <= 1'b1;
    peerMac <= OWN_MAC + 48'h1;
    @(posedge clk);
    peerValid <= 1'b0;
    repeat (60) @(negedge clk);
    check({63'h0, clockMaster}, 64'h1);
    bus_read(`REG_STATUS);
    check({63'h0, rdData[`STAT_SETTLED]}, 64'h1);
    @(posedge clk);
    peerValid <= 1'b1;
    peerMac <= OWN_MAC - 48'h1;
    @(posedge clk);
    peerValid <= 1'b0;
    repeat (5) @(negedge clk);
    check({63'h0, clockMaster}, 64'h0);
  endtask : test_sync
  // ------------------------------------------------------------
  // verdict, timeout and main sequence
  // ------------------------------------------------------------
  task automatic completeRun();
    $display("checks=%0d mismatches=%0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : completeRun
  // the full sequence takes about 15000 cycles
  always @(posedge clk) begin
    cycleCount++;
    if (cycleCount == 40000) begin
      badCount++;
      completeRun();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    test_reset_values();
    test_local_tick();
    test_schedule();
    test_boundary();
    test_sync();
    completeRun();
  end
endmodule : timestamp_modulo_event_timer_test
`default_nettype wire
